// >>> rtl/rtc_cal_trim_walarm.sv
// month, year, rate-trim and weekly alarm logic of the serial clock
module rtc_cal_trim_walarm (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic xtal_clk,
  input wire logic osc_halt_flag,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [2:0] cur_wday,
  input wire logic month_carry,
  input wire logic weekly_alarm_enable,
  input wire logic wa_flag_clear,
  output logic [7:0] reg_rdata_ff,
  output logic sec_tick_ff,
  output logic [7:0] month_ff,
  output logic [7:0] year_ff,
  output logic weekly_alarm_match_flag_ff
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // crystal edge detection
  // ---------------------------------------------------------------
  logic xtal_rise;

  xtal_edge_sync u_xtal_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(xtal_clk),
    .rise_ff(xtal_rise)
  );

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  logic wr_month;
  logic wr_year;
  logic wr_trim;
  logic wr_wa_min;
  logic wr_wa_hour;
  logic wr_wa_days;

  assign wr_month = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_MONTH);
  assign wr_year = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_YEAR);
  assign wr_trim = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_TRIM);
  assign wr_wa_min = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_WA_MIN);
  assign wr_wa_hour = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_WA_HOUR);
  assign wr_wa_days = reg_wr && (reg_addr == rtc_cal_pkg::ADDR_WA_DAYS);

  // ---------------------------------------------------------------
  // rate-trim register
  // ---------------------------------------------------------------
  logic [6:0] trim_ff;
  logic trim_active_ff;
  logic trim_accept;

  // a write with the lock bit set is dropped entirely
  assign trim_accept = wr_trim &&
                       !reg_wdata[rtc_cal_pkg::TRIM_LOCK_BIT];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_ff <= rtc_cal_pkg::TRIM_RESET;
      trim_active_ff <= 1'b0;
    end
    else if (osc_halt_flag)
    begin
      trim_ff <= rtc_cal_pkg::TRIM_RESET;
      trim_active_ff <= 1'b0;
    end
    else if (trim_accept)
    begin
      trim_ff <= reg_wdata[6:0];
      trim_active_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // second length with trim
  // ---------------------------------------------------------------
  logic at_point;
  logic trim_zero;
  logic skip_ff;
  logic apply;
  logic [6:0] lengthen;
  logic [6:0] shorten;
  logic [15:0] period;

  assign at_point = (cur_sec == rtc_cal_pkg::SEC_00) ||
                    (cur_sec == rtc_cal_pkg::SEC_20) ||
                    (cur_sec == rtc_cal_pkg::SEC_40);
  assign trim_zero = (trim_ff[5:1] == 5'h00);
  assign apply = trim_active_ff && !trim_zero && at_point && !skip_ff;
  assign lengthen = {6'(trim_ff[5:0] - 6'h01), 1'b0};
  assign shorten = {6'(~trim_ff[5:0] + 6'h01), 1'b0};

  always_comb
  begin
    period = rtc_cal_pkg::XTAL_PER_SEC;
    if (apply)
    begin
      if (trim_ff[rtc_cal_pkg::TRIM_SIGN_BIT])
        period = rtc_cal_pkg::XTAL_PER_SEC - {9'h000, shorten};
      else
        period = rtc_cal_pkg::XTAL_PER_SEC + {9'h000, lengthen};
    end
  end

  // a trim write blocks correction until the current second ends;
  // set wins over the clear at the tick
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      skip_ff <= 1'b0;
    else if (trim_accept)
      skip_ff <= 1'b1;
    else if (sec_tick_ff)
      skip_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // one-second prescaler
  // ---------------------------------------------------------------
  logic [15:0] pre_cnt_ff;
  logic pre_last;

  assign pre_last = (pre_cnt_ff >= 16'(period - 16'h0001));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_ff <= 16'h0000;
      sec_tick_ff <= 1'b0;
    end
    else
    begin
      sec_tick_ff <= xtal_rise && pre_last;
      if (xtal_rise)
      begin
        if (pre_last)
          pre_cnt_ff <= 16'h0000;
        else
          pre_cnt_ff <= pre_cnt_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // month and year counters
  // ---------------------------------------------------------------
  logic [4:0] nxt_month;
  logic month_wrap;
  logic [7:0] nxt_year;
  logic year_wrap;

  always_comb
  begin
    month_wrap = (month_ff[4:0] == rtc_cal_pkg::MONTH_LAST);
    if (month_wrap)
      nxt_month = rtc_cal_pkg::MONTH_FIRST;
    else if (month_ff[3:0] == 4'h9)
      nxt_month = 5'h10;
    else
      nxt_month = month_ff[4:0] + 5'h01;
    year_wrap = (year_ff == rtc_cal_pkg::YEAR_LAST);
    if (year_wrap)
      nxt_year = 8'h00;
    else if (year_ff[3:0] == 4'h9)
      nxt_year = {4'(year_ff[7:4] + 4'h1), 4'h0};
    else
      nxt_year = year_ff + 8'h01;
  end

  // host writes take priority over a carry in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      month_ff <= rtc_cal_pkg::MONTH_RESET;
    else if (wr_month)
      month_ff <= reg_wdata & rtc_cal_pkg::MONTH_RD_MASK;
    else if (month_carry)
    begin
      month_ff[4:0] <= nxt_month;
      if (month_wrap && year_wrap)
        month_ff[rtc_cal_pkg::CENTURY_BIT] <=
          ~month_ff[rtc_cal_pkg::CENTURY_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      year_ff <= rtc_cal_pkg::YEAR_RESET;
    else if (wr_year)
      year_ff <= reg_wdata;
    else if (month_carry && month_wrap)
      year_ff <= nxt_year;
  end

  // ---------------------------------------------------------------
  // weekly alarm registers
  // ---------------------------------------------------------------
  logic [7:0] wa_min_ff;
  logic [7:0] wa_hour_ff;
  logic [7:0] wa_days_ff;

  // unused positions are never stored, so they cannot read back
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wa_min_ff <= rtc_cal_pkg::WA_RESET;
      wa_hour_ff <= rtc_cal_pkg::WA_RESET;
      wa_days_ff <= rtc_cal_pkg::WA_RESET;
    end
    else
    begin
      if (wr_wa_min)
        wa_min_ff <= reg_wdata & rtc_cal_pkg::WA_MIN_MASK;
      if (wr_wa_hour)
        wa_hour_ff <= reg_wdata & rtc_cal_pkg::WA_HOUR_MASK;
      if (wr_wa_days)
        wa_days_ff <= reg_wdata & rtc_cal_pkg::WA_DAYS_MASK;
    end
  end

  // ---------------------------------------------------------------
  // weekly alarm compare
  // ---------------------------------------------------------------
  logic [rtc_cal_pkg::WEEKDAYS-1:0] day_hit;
  logic match_now;
  logic match_prev_ff;
  logic [11:0] delay_cnt_ff;

  genvar gi;
  generate
    for (gi = 0; gi < rtc_cal_pkg::WEEKDAYS; gi = gi + 1)
    begin : g_day
      assign day_hit[gi] = wa_days_ff[gi] && (cur_wday == 3'(gi));
    end
  endgenerate

  // hour compared as stored, so 12/32 midnight and noon codes hold
  assign match_now = weekly_alarm_enable && (|day_hit) &&
                     (cur_min == wa_min_ff[6:0]) &&
                     (cur_hour == wa_hour_ff[5:0]);

  // the flag lags the match like the crystal-timed original
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_prev_ff <= 1'b0;
      delay_cnt_ff <= 12'h000;
    end
    else
    begin
      match_prev_ff <= match_now;
      if (match_now && !match_prev_ff)
        delay_cnt_ff <= 12'(rtc_cal_pkg::ALARM_DELAY_CYC);
      else if (!weekly_alarm_enable)
        delay_cnt_ff <= 12'h000;
      else if (delay_cnt_ff != 12'h000)
        delay_cnt_ff <= delay_cnt_ff - 12'h001;
    end
  end

  // set wins over wa_flag_clear in the same cycle; a disable clears ahead of both
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      weekly_alarm_match_flag_ff <= 1'b0;
    else if (!weekly_alarm_enable)
      weekly_alarm_match_flag_ff <= 1'b0;
    else if (delay_cnt_ff == 12'h001)
      weekly_alarm_match_flag_ff <= 1'b1;
    else if (wa_flag_clear)
      weekly_alarm_match_flag_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= 8'h00;
    else
    begin
      case (reg_addr)
        rtc_cal_pkg::ADDR_MONTH:
          reg_rdata_ff <= month_ff & rtc_cal_pkg::MONTH_RD_MASK;
        rtc_cal_pkg::ADDR_YEAR: reg_rdata_ff <= year_ff;
        rtc_cal_pkg::ADDR_TRIM: reg_rdata_ff <= {1'b0, trim_ff};
        rtc_cal_pkg::ADDR_WA_MIN: reg_rdata_ff <= wa_min_ff;
        rtc_cal_pkg::ADDR_WA_HOUR: reg_rdata_ff <= wa_hour_ff;
        rtc_cal_pkg::ADDR_WA_DAYS: reg_rdata_ff <= wa_days_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // age since the match rose, kept apart from the delay counter;
  // the span is too long for a delay range in a property
  logic [11:0] wa_age_ff;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wa_age_ff <= 12'h000;
    else if (match_now && !match_prev_ff)
      wa_age_ff <= 12'h001;
    else if (!weekly_alarm_enable)
      wa_age_ff <= 12'h000;
    else if (wa_age_ff == 12'(rtc_cal_pkg::ALARM_DELAY_CYC))
      wa_age_ff <= 12'h000;
    else if (wa_age_ff != 12'h000)
      wa_age_ff <= wa_age_ff + 12'h001;
  end

  sequence match_rise_s;
    match_now && !match_prev_ff;
  endsequence

  sequence delay_loaded_s;
    delay_cnt_ff == 12'(rtc_cal_pkg::ALARM_DELAY_CYC);
  endsequence

  sequence age_full_s;
    (wa_age_ff == 12'(rtc_cal_pkg::ALARM_DELAY_CYC)) && weekly_alarm_enable;
  endsequence

  halt_clears_trim_a: assert property (
    osc_halt_flag |=> (trim_ff == 7'h00) && !trim_active_ff)
    else $error("trim not cleared under oscillation halt");
  trim_lock_bit_a: assert property (
    (wr_trim && reg_wdata[7] && !osc_halt_flag) |=> $stable(trim_ff))
    else $error("trim changed by a write with lock bit set");
  month_gap_zero_a: assert property (
    (reg_addr == 4'h5) |=> (reg_rdata_ff[6:5] == 2'b00))
    else $error("month register bits 6..5 not zero");
  plain_second_a: assert property (
    (xtal_rise && !apply && pre_cnt_ff == 16'h7fff) |=> sec_tick_ff)
    else $error("uncorrected second not 32768 pulses");
  off_point_a: assert property (
    !at_point |-> (period == 16'h8000))
    else $error("second length changed outside 00/20/40");
  trim_null_a: assert property (
    trim_zero |-> (period == 16'h8000))
    else $error("correction made with zero trim bits");
  write_skip_a: assert property (
    (trim_accept && at_point) |=> (period == 16'h8000) until sec_tick_ff)
    else $error("correction made in the second of a trim write");
  trim_len_a: assert property (
    (apply && !trim_ff[6] && trim_ff[5:0] == 6'h07) |->
      (period == 16'h800c))
    else $error("lengthened second wrong");
  trim_short_a: assert property (
    (apply && trim_ff[6] && trim_ff[5:0] == 6'h3e) |->
      (period == 16'h7ffc))
    else $error("shortened second wrong");
  century_toggle_a: assert property (
    (month_carry && !reg_wr && month_ff[4:0] == 5'h12 &&
     year_ff == 8'h99) |=>
      (year_ff == 8'h00) && (month_ff[7] != $past(month_ff[7])))
    else $error("century flag not toggled at year rollover");
  empty_mask_a: assert property (
    (wa_days_ff[6:0] == 7'h00) |-> !match_now)
    else $error("alarm matched with empty day mask");
  alarm_load_a: assert property (
    match_rise_s |=> delay_loaded_s)
    else $error("alarm delay not started at match");
  alarm_delay_a: assert property (
    age_full_s |=> weekly_alarm_match_flag_ff)
    else $error("alarm flag not set about 61 us after match");
  hour_zero_bits_a: assert property (
    (reg_addr == 4'h9) |=> (reg_rdata_ff[7:6] == 2'b00))
    else $error("alarm hour bits 7..6 not zero");

endmodule

// >>> include/rtc_cal_pkg.sv
// shared constants for the calendar, rate-trim and weekly alarm block
package rtc_cal_pkg;

  // ---------------------------------------------------------------
  // register addresses on the four-bit register port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_WA_MIN = 4'h8;
  localparam logic [3:0] ADDR_WA_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WA_DAYS = 4'ha;

  // ---------------------------------------------------------------
  // field positions and read masks
  // ---------------------------------------------------------------
  localparam int CENTURY_BIT = 7;
  localparam int TRIM_LOCK_BIT = 7;
  localparam int TRIM_SIGN_BIT = 6;
  localparam logic [7:0] MONTH_RD_MASK = 8'h9f;
  localparam logic [7:0] WA_MIN_MASK = 8'h7f;
  localparam logic [7:0] WA_HOUR_MASK = 8'h3f;
  localparam logic [7:0] WA_DAYS_MASK = 8'h7f;
  localparam int WEEKDAYS = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] TRIM_RESET = 7'h00;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [7:0] YEAR_RESET = 8'h00;
  localparam logic [7:0] WA_RESET = 8'h00;

  // ---------------------------------------------------------------
  // calendar limits and trim points, all bcd
  // ---------------------------------------------------------------
  localparam logic [4:0] MONTH_FIRST = 5'h01;
  localparam logic [4:0] MONTH_LAST = 5'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [6:0] SEC_00 = 7'h00;
  localparam logic [6:0] SEC_20 = 7'h20;
  localparam logic [6:0] SEC_40 = 7'h40;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [15:0] XTAL_PER_SEC = 16'h8000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ALARM_DELAY_NS = 61000;
  localparam int ALARM_DELAY_CYC = ALARM_DELAY_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/xtal_edge_sync.sv
// two-flop synchroniser and rising-edge detector for the crystal clock pin
module xtal_edge_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise_ff
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // meta_ff feeds sync_ff only; the edge is taken on settled copies
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      rise_ff <= sync_ff & ~prev_ff;
    end
  end

endmodule

// >>> test/xtal_partner.sv
// crystal source and tick-period meter facing the trimmed-second logic
module xtal_partner (
  input wire logic clock,
  input wire logic sec_tick_ff,
  output logic xtal_clk,
  output int last_period
);
  timeunit 1ns;
  timeprecision 100ps;
  int edges = 0;
  // a crystal runs free, so it never idles between seconds
  initial xtal_clk = 1'b0;
  always #100 xtal_clk = ~xtal_clk;
  always @(posedge xtal_clk) edges++;
  // crystal edges fall on whole 100 ns, rising clock edges never do
  always @(posedge clock)
    if (sec_tick_ff === 1'b1)
    begin
      last_period = edges;
      edges = 0;
    end
endmodule

// >>> test/tb.sv
// self-checking bench for the calendar, trim and weekly alarm block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic xtal_clk;
  logic osc_halt_flag = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [6:0] cur_sec = 7'h00;
  logic [6:0] cur_min = 7'h00;
  logic [5:0] cur_hour = 6'h00;
  logic [2:0] cur_wday = 3'h0;
  logic month_carry = 1'b0;
  logic weekly_alarm_enable = 1'b0;
  logic wa_flag_clear = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic sec_tick_ff;
  logic [7:0] month_ff;
  logic [7:0] year_ff;
  logic weekly_alarm_match_flag_ff;
  int last_period;
  int miscompares = 0;
  int checks_done = 0;

  always #12.5 clock = ~clock;

  rtc_cal_trim_walarm i_rtc_cal_trim_walarm (
    .clock(clock),
    .rst_n(rst_n),
    .xtal_clk(xtal_clk),
    .osc_halt_flag(osc_halt_flag),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .cur_sec(cur_sec),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_wday(cur_wday),
    .month_carry(month_carry),
    .weekly_alarm_enable(weekly_alarm_enable),
    .wa_flag_clear(wa_flag_clear),
    .reg_rdata_ff(reg_rdata_ff),
    .sec_tick_ff(sec_tick_ff),
    .month_ff(month_ff),
    .year_ff(year_ff),
    .weekly_alarm_match_flag_ff(weekly_alarm_match_flag_ff)
  );

  xtal_partner i_xtal_partner (
    .clock(clock),
    .sec_tick_ff(sec_tick_ff),
    .xtal_clk(xtal_clk),
    .last_period(last_period)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    chk($sformatf("register %0h", a), {24'h0, e}, {24'h0, reg_rdata_ff});
  endtask

  task automatic wrd(input logic [3:0] a, input logic [7:0] d,
    input logic [7:0] e);
    wr(a, d);
    rd(a, e);
  endtask

  task automatic wait_tick;
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (sec_tick_ff !== 1'b1 && n < 300000);
    chk("tick timeout", 32'h0, {31'h0, n >= 300000});
  endtask

  // cur_sec moves just after the tick, as an outside counter would;
  // the meter latches one edge after the tick, so look a cycle later
  task automatic second(input logic [6:0] s, input logic wt,
    input logic [7:0] t, input logic [31:0] exp);
    cur_sec = s;
    if (wt)
      wr(rtc_cal_pkg::ADDR_TRIM, t);
    wait_tick();
    @(negedge clock);
    chk("second length", exp, last_period);
  endtask

  task automatic carry(input logic [7:0] m, input logic [7:0] y,
    input logic [7:0] me, input logic [7:0] ye);
    wr(rtc_cal_pkg::ADDR_MONTH, m);
    wr(rtc_cal_pkg::ADDR_YEAR, y);
    @(negedge clock);
    month_carry = 1'b1;
    @(negedge clock);
    month_carry = 1'b0;
    chk("month", {24'h0, me}, {24'h0, month_ff});
    chk("year", {24'h0, ye}, {24'h0, year_ff});
  endtask

  // a short mismatch gives the match condition a fresh rising edge
  task automatic rematch(input logic e);
    @(negedge clock);
    cur_min = 7'h31;
    @(negedge clock);
    cur_min = 7'h30;
    repeat (2600) @(negedge clock);
    chk("match flag", {31'h0, e}, {31'h0, weekly_alarm_match_flag_ff});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic check_regs;
    rd(rtc_cal_pkg::ADDR_TRIM, 8'h00);
    wrd(rtc_cal_pkg::ADDR_MONTH, 8'hf2, 8'h92);
    wrd(rtc_cal_pkg::ADDR_YEAR, 8'h47, 8'h47);
    wrd(rtc_cal_pkg::ADDR_WA_MIN, 8'hff, 8'h7f);
    wrd(rtc_cal_pkg::ADDR_WA_HOUR, 8'hff, 8'h3f);
    wrd(rtc_cal_pkg::ADDR_WA_DAYS, 8'hff, 8'h7f);
    wrd(4'h3, 8'h55, 8'h00);
    wrd(rtc_cal_pkg::ADDR_TRIM, 8'hff, 8'h00);
  endtask

  task automatic check_calendar;
    carry(8'h92, 8'h99, 8'h01, 8'h00);
    carry(8'h12, 8'h99, 8'h81, 8'h00);
    carry(8'h05, 8'h47, 8'h06, 8'h47);
  endtask

  task automatic check_alarm;
    int n;
    wrd(rtc_cal_pkg::ADDR_WA_MIN, 8'h30, 8'h30);
    wrd(rtc_cal_pkg::ADDR_WA_HOUR, 8'h32, 8'h32);
    wrd(rtc_cal_pkg::ADDR_WA_DAYS, 8'h08, 8'h08);
    @(negedge clock);
    cur_min = 7'h30;
    cur_hour = 6'h32;
    cur_wday = 3'h3;
    weekly_alarm_enable = 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (weekly_alarm_match_flag_ff !== 1'b1 && n < 3000);
    chk("alarm delay", 32'h989, n);
    @(negedge clock);
    wa_flag_clear = 1'b1;
    @(negedge clock);
    wa_flag_clear = 1'b0;
    repeat (2600) @(negedge clock);
    chk("flag cleared", 32'h0, {31'h0, weekly_alarm_match_flag_ff});
    rematch(1'b1);
    weekly_alarm_enable = 1'b0;
    @(negedge clock);
    chk("flag disabled", 32'h0, {31'h0, weekly_alarm_match_flag_ff});
    cur_wday = 3'h4;
    weekly_alarm_enable = 1'b1;
    rematch(1'b0);
    cur_wday = 3'h3;
    cur_hour = 6'h12;
    rematch(1'b0);
    // mask emptied before the hour matches again, or a match starts
    wrd(rtc_cal_pkg::ADDR_WA_DAYS, 8'h00, 8'h00);
    cur_hour = 6'h32;
    rematch(1'b0);
  endtask

  task automatic check_trim;
    wait_tick();
    second(7'h01, 1'b1, 8'h07, 32'h8000);
    second(7'h20, 1'b0, 8'h00, 32'h800c);
    second(7'h40, 1'b1, 8'h7e, 32'h8000);
    second(7'h00, 1'b0, 8'h00, 32'h7ffc);
    second(7'h21, 1'b1, 8'h41, 32'h8000);
    second(7'h00, 1'b0, 8'h00, 32'h8000);
  endtask

  task automatic check_halt;
    @(negedge clock);
    osc_halt_flag = 1'b1;
    rd(rtc_cal_pkg::ADDR_TRIM, 8'h00);
    wrd(rtc_cal_pkg::ADDR_TRIM, 8'h05, 8'h00);
    osc_halt_flag = 1'b0;
    wrd(rtc_cal_pkg::ADDR_TRIM, 8'h85, 8'h00);
    wrd(rtc_cal_pkg::ADDR_TRIM, 8'h05, 8'h05);
  endtask

  // a reset in mid-run brings the registers back to their start values
  task automatic check_reset;
    @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    chk("month reset", {24'h0, rtc_cal_pkg::MONTH_RESET},
      {24'h0, month_ff});
    chk("year reset", {24'h0, rtc_cal_pkg::YEAR_RESET},
      {24'h0, year_ff});
    rst_n = 1'b1;
    rd(rtc_cal_pkg::ADDR_TRIM, {1'b0, rtc_cal_pkg::TRIM_RESET});
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    check_regs();
    check_calendar();
    check_alarm();
    check_trim();
    check_halt();
    check_reset();
    finish_test();
  end

  // seven seconds of the trim check at 8 clocks per crystal pulse dominate the run
  initial
  begin
    repeat (2500000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule
